// *** boundary_scan_and_debug_access_tb_top.sv ***
// self-checking bench for the scan instructions and debug access port
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_and_debug_access_tb_top;
    import bsd_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        tck, tms, tdi, tdo, tdo_oe, bsc_active, protected_state, ap_req_ready, ap_rsp_valid;
    logic        dp_tdo = 1'b0;
    logic        dp_tdo_oe = 1'b1;
    logic        flash_secure = 1'b0;
    logic        chip_erase_done = 1'b0;
    logic        ext_rst_b = 1'b1;
    logic        sys_started = 1'b1;
    logic        ap_req_valid = 1'b0;
    logic [7:0]  pin_in = 8'ha5;
    logic [7:0]  core_out = 8'h5a;
    logic [7:0]  pin_out, core_in, o;
    bsd_ap_req_t ap_req = '0;
    bsd_ap_rsp_t ap_rsp, rsp;
    bsd_ahb_m_t  ahb_m, seen;
    int          mismatches = 0;
    int          n_tests = 0;
    always #20 ref_clk = ~ref_clk;
    bsd_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .dp_tdo(dp_tdo), .dp_tdo_oe(dp_tdo_oe), .bsc_active(bsc_active), .pin_in(pin_in),
        .pin_out(pin_out), .core_out(core_out), .core_in(core_in), .flash_secure(flash_secure),
        .chip_erase_done(chip_erase_done), .ext_rst_b(ext_rst_b), .sys_started(sys_started),
        .protected_state(protected_state), .ap_req_valid(ap_req_valid), .ap_req(ap_req),
        .ap_req_ready(ap_req_ready), .ap_rsp_valid(ap_rsp_valid), .ap_rsp(ap_rsp), .ahb_m(ahb_m),
        .ahb_hready(1'b1), .ahb_hresp(1'b0), .ahb_hrdata(32'h44332211));
    bsd_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic ir(input logic [3:0] c, input logic [3:0] cap);
        u_tst.scan(1'b1, {4'h0, c}, 4, o);
        check(32'(o), 32'(cap));
    endtask
    task automatic dr(input logic [7:0] d, input int n, input logic [7:0] e);
        u_tst.scan(1'b0, d, n, o);
        check(32'(o), 32'(e));
    endtask
    // one request: hold valid until taken, then wait for the answer
    task automatic ap(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        ap_req_valid <= 1'b1;
        ap_req <= '{w, 3'h0, a, d};
        for (k = 0; k < 20 && ap_req_ready !== 1'b1; k++)
            @(negedge ref_clk);
        if (k >= 20) begin
            mismatches++;
            print_verdict();
        end
        @(posedge ref_clk);
        ap_req_valid <= 1'b0;
        seen = '0;
        for (k = k; k < 40 && ap_rsp_valid !== 1'b1; k++) begin
            @(negedge ref_clk);
            if (ahb_m.htrans === BSD_HTRANS_NONSEQ)
                seen = ahb_m;
        end
        if (k >= 40) begin
            mismatches++;
            print_verdict();
        end
        rsp = ap_rsp;
    endtask
    task automatic t_sample();
        ir(BSD_IR_SAMPLE, 4'h8);
        check(32'(pin_out), 32'(core_out));
        dr(8'h3c, 8, 8'ha5);
        check(32'(pin_out), 32'(core_out));
        check(32'(bsc_active), 32'h1);
        check(32'(tdo_oe), 32'h0);
    endtask
    task automatic t_extest();
        ir(BSD_IR_EXTEST, 4'h8);
        dr(8'h3c, 8, 8'ha5);
        check(32'(pin_out), 32'h3c);
        @(posedge ref_clk);
        pin_in <= 8'h96;
        dr(8'hc3, 8, 8'h96);
        check(32'(pin_out), 32'hc3);
    endtask
    task automatic t_clamp();
        ir(BSD_IR_CLAMP, 4'h8);
        check(32'(pin_out), 32'hc3);
        dr(8'h03, 2, 8'h02);
    endtask
    task automatic t_intest();
        @(posedge ref_clk);
        sys_started <= 1'b0;
        ir(BSD_IR_INTEST, 4'h0);
        dr(8'h69, 8, 8'h5a);
        check(32'(core_in), 32'h69);
        check(32'(pin_out), 32'h69);
        ir(BSD_IR_BYPASS, 4'h8);
        @(posedge ref_clk);
        sys_started <= 1'b1;
    endtask
    task automatic t_bypass();
        dr(8'h03, 2, 8'h02);
        check(32'(pin_out), 32'(core_out));
        ir(4'h3, 4'h8);
        check(32'(bsc_active), 32'h0);
        @(posedge ref_clk);
        dp_tdo <= 1'b1;
        @(negedge ref_clk);
        check(32'(tdo), 32'h1);
        check(32'(tdo_oe), 32'h1);
    endtask
    task automatic t_ap();
        ap(1'b1, 32'h20000001, 32'h000000ab);
        check(32'({seen.htrans, seen.hburst, seen.hwrite, seen.nomap}), 32'h43);
        check(seen.haddr, 32'h20000001);
        check(seen.hwdata, 32'h0000ab00);
        check(32'(rsp.err), 32'h0);
        ap(1'b0, 32'h20000002, 32'h0);
        check(rsp.rdata, 32'h00004433);
        check(32'(seen.nomap), 32'h1);
    endtask
    task automatic t_ext_rst();
        @(posedge ref_clk);
        ext_rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ap(1'b0, 32'h20000000, 32'h0);
        check(32'({rsp.err, seen.htrans}), 32'h4);
        @(posedge ref_clk);
        ext_rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_protect();
        flash_secure <= 1'b1;
        ap(1'b0, 32'h20000000, 32'h0);
        check(32'({rsp.err, protected_state}), 32'h0);
        do_reset();
        check(32'(protected_state), 32'h1);
        ir(BSD_IR_BYPASS, 4'h9);
        ap(1'b0, 32'h20000000, 32'h0);
        check(32'({rsp.err, seen.htrans}), 32'h4);
        chip_erase_done <= 1'b1;
        @(posedge ref_clk);
        chip_erase_done <= 1'b0;
        ap(1'b0, 32'h20000000, 32'h0);
        check(32'({rsp.err, protected_state}), 32'h0);
    endtask
    initial begin
        do_reset();
        t_sample();
        t_extest();
        t_clamp();
        t_intest();
        t_bypass();
        t_ap();
        t_ext_rst();
        t_protect();
        print_verdict();
    end
endmodule
`default_nettype wire

// *** bsd_pkg.sv ***
// shared constants and types for the boundary-scan and debug access block
`default_nettype none
package bsd_pkg;
    // instruction register
    localparam int         BSD_IR_W      = 4;
    localparam logic [3:0] BSD_IR_EXTEST = 4'h0;
    localparam logic [3:0] BSD_IR_SAMPLE = 4'h1;
    localparam logic [3:0] BSD_IR_INTEST = 4'h4;
    localparam logic [3:0] BSD_IR_CLAMP  = 4'h5;
    localparam logic [3:0] BSD_IR_BYPASS = 4'hf;
    // status pattern captured into the instruction shifter, bit 0 leaves first
    localparam int         BSD_CAP_PROT  = 0;
    localparam int         BSD_CAP_LAST  = 3;
    localparam logic [3:0] BSD_CAP_ZERO  = 4'h0;
    // boundary-scan chain, one cell per pin, cell 0 nearest the data-out pin
    localparam int         BSD_CHAIN_LEN = 8;
    localparam logic       BSD_BYP_CAPTURE = 1'b0;
    // bus master encodings
    localparam logic [1:0] BSD_HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] BSD_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] BSD_HBURST_SINGLE = 3'h0;
    localparam logic [3:0] BSD_HPROT_DATA    = 4'h3;
    localparam int         BSD_LANE_LSB      = 0;
    localparam int         BSD_LANE_W        = 2;
    localparam int         BSD_BYTE_SHIFT    = 3;

    typedef enum logic [15:0] {
        BSD_TAP_RESET   = 16'h0001,
        BSD_TAP_IDLE    = 16'h0002,
        BSD_DR_SELECT   = 16'h0004,
        BSD_DR_CAPTURE  = 16'h0008,
        BSD_DR_SHIFT    = 16'h0010,
        BSD_DR_EXIT1    = 16'h0020,
        BSD_DR_PAUSE    = 16'h0040,
        BSD_DR_EXIT2    = 16'h0080,
        BSD_DR_UPDATE   = 16'h0100,
        BSD_IR_SELECT   = 16'h0200,
        BSD_IR_CAPTURE  = 16'h0400,
        BSD_IR_SHIFT    = 16'h0800,
        BSD_IR_EXIT1    = 16'h1000,
        BSD_IR_PAUSE    = 16'h2000,
        BSD_IR_EXIT2    = 16'h4000,
        BSD_IR_UPDATE   = 16'h8000
    } bsd_tap_state_t;

    typedef enum logic [2:0] {
        BSD_AP_IDLE = 3'h1,
        BSD_AP_ADDR = 3'h2,
        BSD_AP_DATA = 3'h4
    } bsd_ap_state_t;

    typedef struct packed {
        logic        write;
        logic [2:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bsd_ap_req_t;

    typedef struct packed {
        logic        err;
        logic [31:0] rdata;
    } bsd_ap_rsp_t;

    typedef struct packed {
        logic [1:0]  htrans;
        logic [31:0] haddr;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [2:0]  hburst;
        logic [3:0]  hprot;
        logic [31:0] hwdata;
        logic        nomap;
    } bsd_ahb_m_t;
endpackage
`default_nettype wire

// *** bsd_tester.sv ***
// scan tester model: drives the test pins and collects data out
`timescale 1ns/100ps
`default_nettype none
module bsd_tester (
    // test access pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 48 ns period; tck rests low between frames, data out taken before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #24;
        q = tdo;
        tck = 1'b1;
        #24;
        tck = 1'b0;
    endtask
    // idle, walk to capture, shift n bits, update, back to idle
    task automatic scan(input logic ir, input logic [7:0] din, input int n, output logic [7:0] dout);
        logic q;
        dout = 8'h00;
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b1, 1'b0, q);
        if (ir)
            step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule
`default_nettype wire

// *** bsd_top.sv ***
// boundary-scan instruction logic and protected debug memory access port
// Functional notes
// - protected state locks the debug memory access port
// - only chip erase restores access
// - new protection reported only after system reset
// - scan data shifts LSB first, MSB last
// - capture-IR loads protection, zeros, startup bit
// - startup bit and protection bit reflect live state
// - external test selects chain, drives latched outputs
// - external test captures pins, shifts, updates outputs
// - sample/preload captures pins, never updates latch
// - internal test selects chain, capture ends in one
// - internal test captures core, drives core inputs
// - clamp selects bypass, pins driven from chain
// - clamp bypass captures zero, shifts one bit
// - port issues single non-sequential transfers only
// - unaligned and bit-band transfers passed to interconnect
// - transfers bypass protection checks and flash patching
// - transfers use little-endian byte lanes
// - access refused while external reset asserted
// - access independent of processor run state
// - recognised instruction routes our serial output
// - all-ones code is bypass, one-bit path
`timescale 1ns/100ps
`default_nettype none
module bsd_top (
    // system clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              rst_b,
    // test access port pins, tck clocks the scan logic
    input  wire logic                              tck,
    input  wire logic                              tms,
    input  wire logic                              tdi,
    output logic                                   tdo,
    output logic                                   tdo_oe,
    // debug port serial output and its enable
    input  wire logic                              dp_tdo,
    input  wire logic                              dp_tdo_oe,
    output logic                                   bsc_active,
    // boundary-scan cells
    input  wire logic [bsd_pkg::BSD_CHAIN_LEN-1:0] pin_in,
    output logic      [bsd_pkg::BSD_CHAIN_LEN-1:0] pin_out,
    input  wire logic [bsd_pkg::BSD_CHAIN_LEN-1:0] core_out,
    output logic      [bsd_pkg::BSD_CHAIN_LEN-1:0] core_in,
    // protection and system status
    input  wire logic                              flash_secure,
    input  wire logic                              chip_erase_done,
    input  wire logic                              ext_rst_b,
    input  wire logic                              sys_started,
    output logic                                   protected_state,
    // debug access requests
    input  wire logic                              ap_req_valid,
    input  wire bsd_pkg::bsd_ap_req_t              ap_req,
    output logic                                   ap_req_ready,
    output logic                                   ap_rsp_valid,
    output var bsd_pkg::bsd_ap_rsp_t               ap_rsp,
    // system bus master
    output var bsd_pkg::bsd_ahb_m_t                ahb_m,
    input  wire logic                              ahb_hready,
    input  wire logic                              ahb_hresp,
    input  wire logic [31:0]                       ahb_hrdata
);
    import bsd_pkg::*;

    localparam int N = BSD_CHAIN_LEN;

    function automatic logic bsd_uses_chain(input logic [BSD_IR_W-1:0] ir);
        bsd_uses_chain = (ir == BSD_IR_EXTEST) || (ir == BSD_IR_SAMPLE) || (ir == BSD_IR_INTEST);
    endfunction

    function automatic logic bsd_known(input logic [BSD_IR_W-1:0] ir);
        bsd_known = bsd_uses_chain(ir) || (ir == BSD_IR_CLAMP) || (ir == BSD_IR_BYPASS);
    endfunction

    function automatic logic [4:0] bsd_lane_shift(input logic [31:0] addr);
        bsd_lane_shift = 5'(addr[BSD_LANE_LSB +: BSD_LANE_W]) << BSD_BYTE_SHIFT;
    endfunction

    // ---------------- system clock domain ----------------
    logic          load_pend_q;
    logic          prot_q;
    logic          prot_d;
    logic          ext_s1_q;
    logic          ext_s2_q;
    bsd_ap_state_t ap_q;
    bsd_ap_state_t ap_d;
    bsd_ahb_m_t    ahb_q;
    bsd_ap_rsp_t   rsp_q;
    logic          rsp_valid_q;
    logic [4:0]    lane_q;

    // protection is caught once per system reset, so a newly set fuse waits for it
    assign prot_d = load_pend_q ? flash_secure : (prot_q & ~chip_erase_done);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            load_pend_q <= 1'b1;
            prot_q      <= 1'b0;
            ext_s1_q    <= 1'b0;
            ext_s2_q    <= 1'b0;
        end else begin
            load_pend_q <= 1'b0;
            prot_q      <= prot_d;
            ext_s1_q    <= ext_rst_b;
            ext_s2_q    <= ext_s1_q;
        end
    end

    assign protected_state = prot_q;

    // access is refused under protection or external reset, whatever the processor does
    wire ap_deny   = prot_q | ~ext_s2_q;
    wire ap_accept = ap_req_valid & ap_req_ready;
    wire ap_go     = ap_accept & ~ap_deny;

    // ready drops while a transfer or its answer is pending, so beats never run back to back
    assign ap_req_ready = (ap_q == BSD_AP_IDLE) & ~rsp_valid_q;

    always_comb begin
        ap_d = ap_q;
        case (ap_q)
            BSD_AP_IDLE: if (ap_go) ap_d = BSD_AP_ADDR;
            BSD_AP_ADDR: if (ahb_hready) ap_d = BSD_AP_DATA;
            BSD_AP_DATA: if (ahb_hready) ap_d = BSD_AP_IDLE;
            default:     ap_d = BSD_AP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ap_q        <= BSD_AP_IDLE;
            ahb_q       <= '0;
            rsp_q       <= '0;
            rsp_valid_q <= 1'b0;
            lane_q      <= '0;
        end else begin
            ap_q        <= ap_d;
            rsp_valid_q <= 1'b0;
            if (ap_q == BSD_AP_IDLE && ap_go) begin
                // one non-sequential single beat, address passed unaligned as given
                ahb_q.htrans <= BSD_HTRANS_NONSEQ;
                ahb_q.haddr  <= ap_req.addr;
                ahb_q.hwrite <= ap_req.write;
                ahb_q.hsize  <= ap_req.size;
                ahb_q.hburst <= BSD_HBURST_SINGLE;
                ahb_q.hprot  <= BSD_HPROT_DATA;
                ahb_q.hwdata <= ap_req.wdata << bsd_lane_shift(ap_req.addr);
                ahb_q.nomap  <= 1'b1;
                lane_q       <= bsd_lane_shift(ap_req.addr);
            end else if (ap_q == BSD_AP_IDLE && ap_accept) begin
                rsp_q       <= '{err: 1'b1, rdata: '0};
                rsp_valid_q <= 1'b1;
            end else if (ap_q == BSD_AP_ADDR && ahb_hready) begin
                ahb_q.htrans <= BSD_HTRANS_IDLE;
            end else if (ap_q == BSD_AP_DATA && ahb_hready) begin
                rsp_q       <= '{err: ahb_hresp, rdata: ahb_hrdata >> lane_q};
                rsp_valid_q <= 1'b1;
                ahb_q.nomap <= 1'b0;
            end
        end
    end

    assign ahb_m        = ahb_q;
    assign ap_rsp       = rsp_q;
    assign ap_rsp_valid = rsp_valid_q;

    // ---------------- test clock domain ----------------
    bsd_tap_state_t tap_q;
    bsd_tap_state_t tap_d;
    logic [3:0]     ir_shift_q;
    logic [3:0]     ir_q;
    logic [N-1:0]   bsr_shift_q;
    logic [N-1:0]   bsr_upd_q;
    logic           byp_q;
    logic           tdo_q;
    logic           tdo_oe_q;
    logic           prot_s1_q;
    logic           prot_s2_q;
    logic           start_s1_q;
    logic           start_s2_q;
    logic [N-1:0]   pin_s1_q;
    logic [N-1:0]   pin_s2_q;
    logic [N-1:0]   core_s1_q;
    logic [N-1:0]   core_s2_q;

    always_comb begin
        tap_d = tap_q;
        case (tap_q)
            BSD_TAP_RESET:  tap_d = tms ? BSD_TAP_RESET  : BSD_TAP_IDLE;
            BSD_TAP_IDLE:   tap_d = tms ? BSD_DR_SELECT  : BSD_TAP_IDLE;
            BSD_DR_SELECT:  tap_d = tms ? BSD_IR_SELECT  : BSD_DR_CAPTURE;
            BSD_DR_CAPTURE: tap_d = tms ? BSD_DR_EXIT1   : BSD_DR_SHIFT;
            BSD_DR_SHIFT:   tap_d = tms ? BSD_DR_EXIT1   : BSD_DR_SHIFT;
            BSD_DR_EXIT1:   tap_d = tms ? BSD_DR_UPDATE  : BSD_DR_PAUSE;
            BSD_DR_PAUSE:   tap_d = tms ? BSD_DR_EXIT2   : BSD_DR_PAUSE;
            BSD_DR_EXIT2:   tap_d = tms ? BSD_DR_UPDATE  : BSD_DR_SHIFT;
            BSD_DR_UPDATE:  tap_d = tms ? BSD_DR_SELECT  : BSD_TAP_IDLE;
            BSD_IR_SELECT:  tap_d = tms ? BSD_TAP_RESET  : BSD_IR_CAPTURE;
            BSD_IR_CAPTURE: tap_d = tms ? BSD_IR_EXIT1   : BSD_IR_SHIFT;
            BSD_IR_SHIFT:   tap_d = tms ? BSD_IR_EXIT1   : BSD_IR_SHIFT;
            BSD_IR_EXIT1:   tap_d = tms ? BSD_IR_UPDATE  : BSD_IR_PAUSE;
            BSD_IR_PAUSE:   tap_d = tms ? BSD_IR_EXIT2   : BSD_IR_PAUSE;
            BSD_IR_EXIT2:   tap_d = tms ? BSD_IR_UPDATE  : BSD_IR_SHIFT;
            BSD_IR_UPDATE:  tap_d = tms ? BSD_DR_SELECT  : BSD_TAP_IDLE;
            default:        tap_d = BSD_TAP_RESET;
        endcase
    end

    // decoded instruction
    wire is_extest = (ir_q == BSD_IR_EXTEST);
    wire is_sample = (ir_q == BSD_IR_SAMPLE);
    wire is_intest = (ir_q == BSD_IR_INTEST);
    wire is_clamp  = (ir_q == BSD_IR_CLAMP);
    wire on_chain  = bsd_uses_chain(ir_q);
    wire drive_pins = is_extest | is_intest | is_clamp;

    // status pattern: protection first out, last bit startup or constant one for internal test
    wire       cap_last = is_intest ? 1'b1 : start_s2_q;
    wire [3:0] ir_cap   = {cap_last, BSD_CAP_ZERO[BSD_CAP_LAST-1:BSD_CAP_PROT+1], prot_s2_q};

    // capture source: pins for external test and sample, core outputs for internal test
    wire [N-1:0] bsr_cap = is_intest ? core_s2_q : pin_s2_q;

    wire shifting = (tap_q == BSD_IR_SHIFT) || (tap_q == BSD_DR_SHIFT);
    wire ser_out  = (tap_q == BSD_IR_SHIFT) ? ir_shift_q[0]
                  : (on_chain ? bsr_shift_q[0] : byp_q);

    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            prot_s1_q  <= 1'b0;
            prot_s2_q  <= 1'b0;
            start_s1_q <= 1'b0;
            start_s2_q <= 1'b0;
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
            core_s1_q  <= '0;
            core_s2_q  <= '0;
        end else begin
            prot_s1_q  <= prot_q;
            prot_s2_q  <= prot_s1_q;
            start_s1_q <= sys_started;
            start_s2_q <= start_s1_q;
            pin_s1_q   <= pin_in;
            pin_s2_q   <= pin_s1_q;
            core_s1_q  <= core_out;
            core_s2_q  <= core_s1_q;
        end
    end

    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            tap_q      <= BSD_TAP_RESET;
            ir_shift_q <= '0;
            ir_q       <= BSD_IR_BYPASS;
        end else begin
            tap_q <= tap_d;
            case (tap_q)
                BSD_TAP_RESET:  ir_q       <= BSD_IR_BYPASS;
                BSD_IR_CAPTURE: ir_shift_q <= ir_cap;
                BSD_IR_SHIFT:   ir_shift_q <= {tdi, ir_shift_q[3:1]};
                BSD_IR_UPDATE:  ir_q       <= ir_shift_q;
                default:        ir_q       <= ir_q;
            endcase
        end
    end

    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            bsr_shift_q <= '0;
            bsr_upd_q   <= '0;
            byp_q       <= 1'b0;
        end else begin
            if (tap_q == BSD_DR_CAPTURE && on_chain) bsr_shift_q <= bsr_cap;
            if (tap_q == BSD_DR_SHIFT && on_chain) bsr_shift_q <= {tdi, bsr_shift_q[N-1:1]};
            // sample/preload leaves the latch alone
            if (tap_q == BSD_DR_UPDATE && (is_extest | is_intest)) bsr_upd_q <= bsr_shift_q;
            if (tap_q == BSD_DR_CAPTURE) byp_q <= BSD_BYP_CAPTURE;
            if (tap_q == BSD_DR_SHIFT) byp_q <= tdi;
        end
    end

    // serial output changes on the falling edge so the tester samples it clean
    always_ff @(negedge tck or negedge rst_b) begin
        if (!rst_b) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= ser_out;
            tdo_oe_q <= shifting;
        end
    end

    assign bsc_active = bsd_known(ir_q);
    assign tdo        = bsc_active ? tdo_q : dp_tdo;
    assign tdo_oe     = bsc_active ? tdo_oe_q : dp_tdo_oe;
    assign pin_out    = drive_pins ? bsr_upd_q : core_out;
    assign core_in    = is_intest ? bsr_upd_q : pin_in;

    // ---------------- assertions ----------------
    a_ir_status_cap: assert property (@(posedge tck) disable iff (!rst_b)
        (tap_q == BSD_IR_CAPTURE && !is_intest) |=>
            ir_shift_q == {$past(start_s2_q), 2'h0, $past(prot_s2_q)})
        else $error("ir capture pattern wrong");

    a_intest_cap_one: assert property (@(posedge tck) disable iff (!rst_b)
        (tap_q == BSD_IR_CAPTURE && is_intest) |=> ir_shift_q[BSD_CAP_LAST])
        else $error("intest capture must end in one");

    a_ir_lsb_first: assert property (@(posedge tck) disable iff (!rst_b)
        (tap_q == BSD_IR_SHIFT) ##1 (tap_q == BSD_IR_SHIFT) ##1 (tap_q == BSD_IR_EXIT1) |->
            ir_shift_q[3:2] == {$past(tdi), $past(tdi, 2)})
        else $error("ir not shifted lsb first");

    a_sample_no_upd: assert property (@(posedge tck) disable iff (!rst_b)
        (tap_q == BSD_DR_UPDATE && is_sample) |=> $stable(bsr_upd_q))
        else $error("sample updated the output latch");

    a_extest_pins: assert property (@(posedge tck) disable iff (!rst_b)
        (tap_q == BSD_IR_UPDATE && ir_shift_q == BSD_IR_EXTEST) |=> pin_out == bsr_upd_q)
        else $error("extest pins not from latch");

    a_clamp_byp_zero: assert property (@(posedge tck) disable iff (!rst_b)
        (tap_q == BSD_DR_CAPTURE && is_clamp) |=> !byp_q)
        else $error("clamp bypass did not capture zero");

    a_intest_core_in: assert property (@(posedge tck) disable iff (!rst_b)
        is_intest |-> (core_in == bsr_upd_q && pin_out == bsr_upd_q))
        else $error("intest not driving from chain");

    a_sample_pins_free: assert property (@(posedge tck) disable iff (!rst_b)
        is_sample |-> (pin_out == core_out && core_in == pin_in))
        else $error("sample disturbed system pins");

    a_tdo_route: assert property (@(posedge tck) disable iff (!rst_b)
        (tap_q == BSD_TAP_RESET) |=> (tdo == tdo_q))
        else $error("bypass after reset must own data-out");

    a_lock_denies: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ap_accept && prot_q) |=> (ap_rsp_valid && ap_rsp.err && ap_q == BSD_AP_IDLE)
            ##1 (ahb_m.htrans == BSD_HTRANS_IDLE))
        else $error("protected access reached the bus");

    a_ext_rst_deny: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ap_accept && !ext_s2_q) |=> (ap_rsp_valid && ap_rsp.err))
        else $error("access during external reset");

    a_single_beat: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ahb_m.htrans == BSD_HTRANS_NONSEQ && ahb_hready) |=>
            (ahb_m.htrans == BSD_HTRANS_IDLE) ##1 (ahb_m.htrans == BSD_HTRANS_IDLE))
        else $error("back-to-back transfer issued");

    a_prot_at_reset: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(prot_q) |-> $past(load_pend_q))
        else $error("protection reported before reset");

    a_erase_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (chip_erase_done && !load_pend_q) |=> !prot_q ##1 !prot_q)
        else $error("chip erase did not clear protection");

    c_extest_update: cover property (@(posedge tck) disable iff (!rst_b)
        tap_q == BSD_DR_UPDATE && is_extest);
    c_intest_capture: cover property (@(posedge tck) disable iff (!rst_b)
        tap_q == BSD_DR_CAPTURE && is_intest);
    c_clamp_shift: cover property (@(posedge tck) disable iff (!rst_b)
        tap_q == BSD_DR_SHIFT && is_clamp);
    c_ap_done: cover property (@(posedge ref_clk) disable iff (!rst_b)
        ap_rsp_valid && !ap_rsp.err);
    c_ap_denied: cover property (@(posedge ref_clk) disable iff (!rst_b)
        ap_rsp_valid && ap_rsp.err && prot_q);
endmodule
`default_nettype wire
